// ---- design/pcb_delay_line.sv ----
`timescale 1ns/1ns
`default_nettype none

// Event delay line, stepped by the quarter-rate edge, tapped by latency
module pcb_delay_line #(
  parameter int DEPTH = 16,
  parameter int SEL_W = 4
) (
  // Clock and reset
  input  wire logic             clk_in,
  input  wire logic             reset_in,
  // Shift side
  input  wire logic             step_in,
  input  wire logic             bit_in,
  // Tap side
  input  wire logic [SEL_W-1:0] tap_sel_in,
  output logic                  tap_out
);

  logic [DEPTH-1:0] line;
  wire  [DEPTH-1:0] next_line = {line[DEPTH-2:0], bit_in};

  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      line <= '0;
    end else if (step_in) begin
      line <= next_line;
    end
  end

  // Registered tap stands in for the clock-to-pin delay
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      tap_out <= 1'b0;
    end else begin
      tap_out <= line[tap_sel_in];
    end
  end

endmodule // pcb_delay_line

`default_nettype wire

// ---- design/pcb_parity_hold.sv ----
`timescale 1ns/1ns
`default_nettype none

// Contract
// - Check parity only while parity enable bit 0 is set; off at reset.
// - Training-exit and sleep-exit commands are never parity checked.
// - With hold enabled, confirm parity before executing a command.
// - Command hold is disabled out of reset.
// - Held commands wait for parity, then release and execute.
// - Report supported hold latency style in info word three bits 3:2.
// - With both styles, bit 6 picks explicit; otherwise bit ignored.
// - Failing command and its companion bus command are not executed.
// - Commands in uncertainty windows before the error may be dropped.
// - After a held error, discard all commands until training entry.
// - Fault pin at minus level one quarter cycle at set latency.
// - Fault appears latency setting times quarter period plus pin delay.
// - Drain work and close pages; reset bank counter on training entry.
// - Unlock wait is refresh time plus precharge, rounded per quarter.
// - Directed refresh time follows bounded refresh configuration.
// - Further parity errors during unlock wait need not be reported.
// - Write checksum faults still reported during unlock wait.
// - Running strobe drops to quarter rate within the switch time.
// - Halted strobe goes high-Z, then toggles at quarter rate.
// - Training exit returns to self refresh; always-on strobe restarts.
module pcb_parity_hold #(
  parameter logic [1:0] STYLE_SUPPORT = pcb_pkg::STYLE_BOTH,
  parameter int QCLK_NS      = pcb_pkg::QCLK_PERIOD_NS,
  parameter int PRECHG_NS    = pcb_pkg::PRECHARGE_NS,
  parameter int ALLBANK_NS   = pcb_pkg::ALL_BANK_NS,
  parameter int DIR0_NS      = pcb_pkg::DIRECTED0_NS,
  parameter int DIR1_NS      = pcb_pkg::DIRECTED1_NS,
  parameter int DIR2_NS      = pcb_pkg::DIRECTED2_NS,
  parameter int DIR3_NS      = pcb_pkg::DIRECTED3_NS
) (
  // Clock and reset
  input  wire logic                      clk_in,
  input  wire logic                      reset_in,
  // Link pins
  input  wire logic                      quarter_rate_clock_in,
  input  wire logic [pcb_pkg::CMD_W-1:0] cmd_row_in,
  input  wire logic [pcb_pkg::CMD_W-1:0] cmd_col_in,
  input  wire logic                      cmd_parity_in,
  // Mode register writes and side inputs
  input  wire logic                      mode_write_in,
  input  wire logic                      mode_sel_in,
  input  wire logic [pcb_pkg::MODE_W-1:0] mode_data_in,
  input  wire logic [1:0]                strobe_mode_in,
  input  wire logic                      write_checksum_fault_in,
  // Execution side
  output logic                           exec_valid_out,
  output logic [pcb_pkg::CMD_W-1:0]      exec_row_out,
  output logic [pcb_pkg::CMD_W-1:0]      exec_col_out,
  output logic                           drain_req_out,
  output logic                           bank_counter_reset_out,
  output logic                           training_active_out,
  output logic                           self_refresh_out,
  // Status
  output logic                           cmd_addr_parity_check_out,
  output logic                           parity_command_hold_out,
  output logic                           hold_latency_style_select_out,
  output logic [3:0]                     info_read_word_three_out,
  // Fault and strobe pins
  output logic [1:0]                     fault_level_out,
  output logic                           read_strobe_clock_out,
  output logic                           read_strobe_clock_oe_out
);

  localparam int W = pcb_pkg::CMD_W;

  // Synchronisers for all link pins
  logic         qclk_s1, qclk_s2, qclk_s3;
  logic [2*W:0] cmd_s1, cmd_s2;

  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      qclk_s1 <= 1'b0;
      qclk_s2 <= 1'b0;
      qclk_s3 <= 1'b0;
      cmd_s1  <= '0;
      cmd_s2  <= '0;
    end else begin
      qclk_s1 <= quarter_rate_clock_in;
      qclk_s2 <= qclk_s1;
      qclk_s3 <= qclk_s2;
      cmd_s1  <= {cmd_parity_in, cmd_col_in, cmd_row_in};
      cmd_s2  <= cmd_s1;
    end
  end

  // Mode registers
  logic [pcb_pkg::MODE_W-1:0] parity_mode;
  logic [pcb_pkg::REF_W-1:0]  refresh_mode;

  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      parity_mode  <= pcb_pkg::PARITY_MODE_RESET;
      refresh_mode <= pcb_pkg::REFRESH_MODE_RESET;
    end else if (mode_write_in) begin
      if (mode_sel_in == pcb_pkg::MODE_SEL_PARITY) begin
        parity_mode <= mode_data_in;
      end else begin
        refresh_mode <= mode_data_in[pcb_pkg::REF_W-1:0];
      end
    end
  end

  // Decode
  pcb_pkg::pcb_state_t state, next_state;
  wire [W-1:0] row      = cmd_s2[W-1:0];
  wire [W-1:0] col      = cmd_s2[2*W-1:W];
  wire         qrise    = qclk_s2 & ~qclk_s3;
  wire         par_en   = parity_mode[pcb_pkg::PAR_EN_BIT];
  // Hold without parity is meaningless; gated by the parity enable bit
  wire         hold_on  = par_en & parity_mode[pcb_pkg::HOLD_BIT];
  wire         exempt   = (col == pcb_pkg::COL_TRAIN_EXIT) |
                          (col == pcb_pkg::COL_SLEEP_EXIT);
  wire         par_bad  = ^cmd_s2;
  wire         cmd_err  = qrise & par_en & ~exempt & par_bad;
  wire         not_idle = (row != pcb_pkg::ROW_IDLE) |
                          (col != pcb_pkg::COL_IDLE);
  wire         in_run   = (state == pcb_pkg::ST_RUN);
  wire         accept   = qrise & in_run & not_idle;
  wire         locking  = cmd_err & hold_on & in_run;
  wire         both_sup = (STYLE_SUPPORT == pcb_pkg::STYLE_BOTH);
  wire         explicit_sel = both_sup ? parity_mode[pcb_pkg::STYLE_BIT]
                          : (STYLE_SUPPORT == pcb_pkg::STYLE_EXPLICIT);
  wire [pcb_pkg::LAT_W-1:0] latency =
    parity_mode[pcb_pkg::LAT_LSB +: pcb_pkg::LAT_W];

  // Hold pipeline: one stage implicit, two explicit
  logic         st1_valid, st2_valid;
  logic [2*W-1:0] st1_cmd, st2_cmd;
  wire          next_st1_valid = accept & hold_on & ~cmd_err;
  wire          rel_valid = explicit_sel ? st2_valid : st1_valid;
  wire [2*W-1:0] rel_cmd  = explicit_sel ? st2_cmd : st1_cmd;

  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      st1_valid <= 1'b0;
      st2_valid <= 1'b0;
      st1_cmd   <= '0;
      st2_cmd   <= '0;
    end else if (qrise) begin
      st1_valid <= next_st1_valid;
      st1_cmd   <= {col, row};
      st2_valid <= st1_valid & explicit_sel;
      st2_cmd   <= st1_cmd;
    end
  end

  // Commands already held ahead of an error still drain out
  wire          next_exec = qrise & (hold_on ? rel_valid
                                             : accept);
  wire [2*W-1:0] next_exec_cmd = hold_on ? rel_cmd : {col, row};

  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      exec_valid_out <= 1'b0;
      exec_row_out   <= '0;
      exec_col_out   <= '0;
    end else begin
      exec_valid_out <= next_exec;
      exec_row_out   <= next_exec_cmd[W-1:0];
      exec_col_out   <= next_exec_cmd[2*W-1:W];
    end
  end

  // Unlock wait in quarter cycles
  logic [pcb_pkg::CNT_W-1:0] unlock_cnt;
  wire [1:0] bounded_cfg = refresh_mode[pcb_pkg::BOUNDED_LSB +: 2];
  wire [pcb_pkg::CNT_W-1:0] dir_cycles =
    (bounded_cfg == 2'h0) ? pcb_pkg::round_up(DIR0_NS, QCLK_NS) :
    (bounded_cfg == 2'h1) ? pcb_pkg::round_up(DIR1_NS, QCLK_NS) :
    (bounded_cfg == 2'h2) ? pcb_pkg::round_up(DIR2_NS, QCLK_NS) :
                            pcb_pkg::round_up(DIR3_NS, QCLK_NS);
  wire [pcb_pkg::CNT_W-1:0] ref_cycles =
    refresh_mode[pcb_pkg::DIRECTED_BIT] ? dir_cycles
      : pcb_pkg::round_up(ALLBANK_NS, QCLK_NS);
  wire [pcb_pkg::CNT_W-1:0] unlock_load = pcb_pkg::CNT_W'(ref_cycles +
    pcb_pkg::round_up(PRECHG_NS, QCLK_NS));
  wire unlock_done = qrise & (unlock_cnt == pcb_pkg::CNT_W'(1));

  always_comb begin
    next_state = state;
    unique case (state)
      pcb_pkg::ST_RUN:
        if (locking) next_state = pcb_pkg::ST_UNLOCK;
      pcb_pkg::ST_UNLOCK:
        if (unlock_done) next_state = pcb_pkg::ST_TRAIN;
      pcb_pkg::ST_TRAIN:
        if (qrise && col == pcb_pkg::COL_TRAIN_EXIT) begin
          next_state = pcb_pkg::ST_SELFREF;
        end
      pcb_pkg::ST_SELFREF:
        if (qrise && col == pcb_pkg::COL_SLEEP_EXIT) begin
          next_state = pcb_pkg::ST_RUN;
        end
    endcase
  end

  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      state      <= pcb_pkg::ST_RUN;
      unlock_cnt <= '0;
    end else begin
      state <= next_state;
      if (locking) begin
        unlock_cnt <= unlock_load;
      end else if (qrise && unlock_cnt != '0) begin
        unlock_cnt <= unlock_cnt - pcb_pkg::CNT_W'(1);
      end
    end
  end

  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      drain_req_out          <= 1'b0;
      bank_counter_reset_out <= 1'b0;
      training_active_out    <= 1'b0;
      self_refresh_out       <= 1'b0;
    end else begin
      drain_req_out       <= (next_state == pcb_pkg::ST_UNLOCK);
      bank_counter_reset_out <= (state == pcb_pkg::ST_UNLOCK) &
                             (next_state == pcb_pkg::ST_TRAIN);
      training_active_out <= (next_state == pcb_pkg::ST_TRAIN);
      self_refresh_out    <= (next_state == pcb_pkg::ST_SELFREF);
    end
  end

  // Errors during the unlock wait are not reported
  logic fault_tap;
  pcb_delay_line #(
    .DEPTH (pcb_pkg::FAULT_DEPTH),
    .SEL_W (pcb_pkg::LAT_W)
  ) u_fault_delay (
    .clk_in     (clk_in),
    .reset_in   (reset_in),
    .step_in    (qrise),
    .bit_in     (cmd_err & in_run),
    .tap_sel_in (latency),
    .tap_out    (fault_tap)
  );

  // Checksum faults: set wins over the clear at the quarter edge
  logic wcf_pending, wcf_active;
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      wcf_pending <= 1'b0;
      wcf_active  <= 1'b0;
    end else begin
      wcf_pending <= write_checksum_fault_in | (wcf_pending & ~qrise);
      if (qrise) begin
        wcf_active <= wcf_pending;
      end
    end
  end

  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      fault_level_out <= pcb_pkg::LVL_PLUS;
    end else begin
      fault_level_out <= (fault_tap | wcf_active) ? pcb_pkg::LVL_MINUS
                                                  : pcb_pkg::LVL_PLUS;
    end
  end

  // Read strobe
  logic strobe_run, strobe_quarter;
  wire  ss_mode = (strobe_mode_in == pcb_pkg::STROBE_STARTSTOP);
  wire  always_mode = (strobe_mode_in == pcb_pkg::STROBE_ALWAYS);
  wire  next_strobe_run =
    always_mode | (ss_mode & (accept & ~locking & col == pcb_pkg::COL_READ |
      strobe_run & ~(accept & col == pcb_pkg::COL_STROBE_HALT)));

  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      strobe_run     <= 1'b0;
      strobe_quarter <= 1'b0;
    end else begin
      unique case (state)
        pcb_pkg::ST_RUN: begin
          strobe_run     <= next_strobe_run;
          strobe_quarter <= locking & strobe_run;
        end
        pcb_pkg::ST_UNLOCK: begin
          strobe_run <= 1'b0;
          if (qrise && ss_mode) begin
            strobe_quarter <= 1'b1;
          end
        end
        pcb_pkg::ST_TRAIN: begin
          if (next_state == pcb_pkg::ST_SELFREF) begin
            strobe_run     <= always_mode;
            strobe_quarter <= 1'b0;
          end
        end
        pcb_pkg::ST_SELFREF: strobe_run <= always_mode;
      endcase
    end
  end

  // Quarter mode follows the link clock, so the first pulse may be short
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      read_strobe_clock_out    <= 1'b0;
      read_strobe_clock_oe_out <= 1'b0;
    end else if (strobe_quarter) begin
      read_strobe_clock_out    <= qclk_s2;
      read_strobe_clock_oe_out <= 1'b1;
    end else if (strobe_run) begin
      read_strobe_clock_out    <= ~read_strobe_clock_out;
      read_strobe_clock_oe_out <= 1'b1;
    end else begin
      read_strobe_clock_out    <= 1'b0;
      read_strobe_clock_oe_out <= 1'b0;
    end
  end

  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      cmd_addr_parity_check_out     <= 1'b0;
      parity_command_hold_out       <= 1'b0;
      hold_latency_style_select_out <= 1'b0;
      info_read_word_three_out      <= '0;
    end else begin
      cmd_addr_parity_check_out     <= par_en;
      parity_command_hold_out       <= hold_on;
      hold_latency_style_select_out <= explicit_sel;
      info_read_word_three_out      <= {STYLE_SUPPORT, 2'h0};
    end
  end

  // Checks
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (reset_in);

  logic [pcb_pkg::LAT_W:0] err_age;
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      err_age <= '1;
    end else if (cmd_err & in_run & qrise) begin
      err_age <= '0;
    end else if (qrise && err_age != '1) begin
      err_age <= err_age + 1'b1;
    end
  end

  sequence s_enter_train;
    state == pcb_pkg::ST_UNLOCK ##1 state == pcb_pkg::ST_TRAIN;
  endsequence
  sequence s_enter_unlock;
    state == pcb_pkg::ST_RUN ##1 state == pcb_pkg::ST_UNLOCK;
  endsequence

  chk_reset_off: assert property ($past(reset_in) |->
    !parity_command_hold_out && !cmd_addr_parity_check_out)
    else $error("hold or parity on after reset");
  chk_error_locks: assert property (locking |=>
    state == pcb_pkg::ST_UNLOCK) else $error("error did not lock");
  chk_failing_held: assert property (cmd_err && hold_on |=>
    !st1_valid) else $error("failing command entered hold");
  chk_train_no_exec: assert property (
    $past(state) == pcb_pkg::ST_TRAIN |-> !exec_valid_out)
    else $error("command executed in training");
  chk_fault_level: assert property ($rose(fault_tap) |=>
    fault_level_out == pcb_pkg::LVL_MINUS) else $error("no minus level");
  chk_fault_latency: assert property (
    $rose(fault_tap) && hold_on && $stable(latency) |->
    err_age == {1'b0, latency}) else $error("fault latency wrong");
  chk_unlock_load: assert property (s_enter_unlock |->
    unlock_cnt == $past(unlock_load)) else $error("unlock load wrong");
  chk_unlock_expiry: assert property (s_enter_train |->
    $past(unlock_cnt, 1) == pcb_pkg::CNT_W'(1)) else $error("early entry");
  chk_bank_reset: assert property (s_enter_train |->
    bank_counter_reset_out ##1 !bank_counter_reset_out)
    else $error("bank counter reset not pulsed");
  chk_checksum_sent: assert property (write_checksum_fault_in |->
    ##[1:20] fault_level_out == pcb_pkg::LVL_MINUS)
    else $error("checksum fault not reported");
  chk_style_fixed: assert property (!both_sup |-> ##1
    hold_latency_style_select_out ==
    (STYLE_SUPPORT == pcb_pkg::STYLE_EXPLICIT))
    else $error("single style not honoured");

endmodule // pcb_parity_hold

`default_nettype wire

// ---- design/pcb_pkg.sv ----
package pcb_pkg;

  // Parity mode register fields
  localparam int MODE_W     = 12;
  localparam int PAR_EN_BIT = 0;
  localparam int HOLD_BIT   = 1;
  localparam int STYLE_BIT  = 6;
  localparam int LAT_LSB    = 8;
  localparam int LAT_W      = 4;
  localparam logic [11:0] PARITY_MODE_RESET = 12'h000;

  // Refresh mode register fields
  localparam int REF_W       = 5;
  localparam int DIRECTED_BIT = 2;
  localparam int BOUNDED_LSB  = 3;
  localparam logic [4:0] REFRESH_MODE_RESET = 5'h00;

  // Mode register selector
  localparam logic MODE_SEL_PARITY  = 1'h0;
  localparam logic MODE_SEL_REFRESH = 1'h1;

  // Command codes on the row and column buses
  localparam int CMD_W = 4;
  localparam logic [3:0] ROW_IDLE       = 4'h0;
  localparam logic [3:0] COL_IDLE       = 4'h0;
  localparam logic [3:0] COL_WRITE      = 4'h1;
  localparam logic [3:0] COL_WRITE_AUTO = 4'h2;
  localparam logic [3:0] COL_READ       = 4'h3;
  localparam logic [3:0] COL_STROBE_HALT = 4'h4;
  localparam logic [3:0] COL_TRAIN_EXIT = 4'h5;
  localparam logic [3:0] COL_SLEEP_EXIT = 4'h6;

  // Hold latency style support codes
  localparam logic [1:0] STYLE_BOTH     = 2'h0;
  localparam logic [1:0] STYLE_EXPLICIT = 2'h2;
  localparam logic [1:0] STYLE_IMPLICIT = 2'h3;

  // Read strobe modes
  localparam logic [1:0] STROBE_OFF       = 2'h0;
  localparam logic [1:0] STROBE_ALWAYS    = 2'h1;
  localparam logic [1:0] STROBE_STARTSTOP = 2'h2;

  // Fault pin levels
  typedef enum logic [1:0] {
    LVL_ZERO  = 2'h0,
    LVL_PLUS  = 2'h1,
    LVL_MINUS = 2'h3
  } pcb_level_t;

  // Gray coded along run, unlock, train, self refresh
  typedef enum logic [1:0] {
    ST_RUN     = 2'h0,
    ST_UNLOCK  = 2'h1,
    ST_TRAIN   = 2'h3,
    ST_SELFREF = 2'h2
  } pcb_state_t;

  // Times in ns
  localparam int QCLK_PERIOD_NS = 800;
  localparam int PRECHARGE_NS   = 18;
  localparam int ALL_BANK_NS    = 280;
  localparam int DIRECTED0_NS   = 100;
  localparam int DIRECTED1_NS   = 200;
  localparam int DIRECTED2_NS   = 300;
  localparam int DIRECTED3_NS   = 400;

  localparam int CNT_W       = 16;
  localparam int FAULT_DEPTH = 16;

  function automatic logic [15:0] round_up(input int t, input int p);
    round_up = 16'((t + p - 1) / p);
  endfunction

endpackage

// ---- tb/ca_parity_command_blocking_test.sv ----
`timescale 1ns/1ns
`default_nettype none

module ca_parity_command_blocking_test;
  localparam int ALLB = 1700;
  localparam int DIR_NS [4] = '{100, 900, 1700, 2500};
  // Stimulus
  logic        clk_in = 1'b0;
  logic        reset_in = 1'b1;
  logic        mode_write_in = 1'b0;
  logic        mode_sel_in = 1'b0;
  logic        write_checksum_fault_in = 1'b0;
  logic [11:0] mode_data_in = 12'h000;
  logic [1:0]  strobe_mode_in = 2'h0;
  logic [8:0]  h_cmd = 9'h000;
  // Link pins and results
  wire logic       quarter_rate_clock_in;
  wire logic       cmd_parity_in;
  wire logic [3:0] cmd_row_in;
  wire logic [3:0] cmd_col_in;
  logic exec_valid_out, drain_req_out, bank_counter_reset_out;
  logic training_active_out, self_refresh_out, read_strobe_clock_out;
  logic cmd_addr_parity_check_out, parity_command_hold_out;
  logic hold_latency_style_select_out, read_strobe_clock_oe_out;
  logic [3:0] exec_row_out, exec_col_out, info_read_word_three_out;
  logic [1:0] fault_level_out;
  logic [7:0] last_cmd;
  logic [15:0] lfsr = 16'h567B;
  logic prev_strobe;
  int miscompares = 0;
  int checked = 0;
  int cycles = 0;
  int n_exec = 0;
  int n_minus, n_drain, n_bank, n_tog, n_tr, n_oe_low;
  time t0, t_exec, t_minus;

  pcb_parity_hold #(
    .ALLBANK_NS(ALLB), .DIR1_NS(900), .DIR2_NS(1700), .DIR3_NS(2500)
  ) dut (
    .clk_in, .reset_in, .quarter_rate_clock_in, .cmd_row_in, .cmd_col_in,
    .cmd_parity_in, .mode_write_in, .mode_sel_in, .mode_data_in,
    .strobe_mode_in, .write_checksum_fault_in, .exec_valid_out,
    .exec_row_out, .exec_col_out, .drain_req_out, .bank_counter_reset_out,
    .training_active_out, .self_refresh_out, .cmd_addr_parity_check_out,
    .parity_command_hold_out, .hold_latency_style_select_out,
    .info_read_word_three_out, .fault_level_out, .read_strobe_clock_out,
    .read_strobe_clock_oe_out
  );

  pcb_host_model host (
    .cmd_in(h_cmd), .qclk_out(quarter_rate_clock_in), .row_out(cmd_row_in),
    .col_out(cmd_col_in), .parity_out(cmd_parity_in)
  );

  function automatic logic [15:0] rnd(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction

  function automatic int ru(input int t);
    return (t + pcb_pkg::QCLK_PERIOD_NS - 1) / pcb_pkg::QCLK_PERIOD_NS;
  endfunction

  function automatic int unlock_wait(input logic d, input int b);
    return ru(d ? DIR_NS[b] : ALLB) + ru(pcb_pkg::PRECHARGE_NS);
  endfunction

  task automatic check(input logic [31:0] seen, exp, input string m);
    checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("wrong value at %0t: %s %0h not %0h", $time, m, seen, exp);
    end
  endtask

  task automatic tally_and_finish();
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task automatic qw(input int n);
    repeat (n) @(posedge quarter_rate_clock_in);
  endtask

  // One quarter cycle on the pins; t0 marks the sampling edge
  task automatic send(input logic [8:0] c);
    @(negedge quarter_rate_clock_in);
    @(posedge clk_in);
    h_cmd <= c;
    @(negedge quarter_rate_clock_in);
    @(posedge quarter_rate_clock_in);
    t0 = $time;
    @(posedge clk_in);
    h_cmd <= 9'h000;
  endtask

  task automatic wr(input logic s, input logic [11:0] d);
    @(posedge clk_in);
    {mode_write_in, mode_sel_in, mode_data_in} <= {1'b1, s, d};
    @(posedge clk_in);
    mode_write_in <= 1'b0;
    repeat (2) @(posedge clk_in);
    @(negedge clk_in);
  endtask

  task automatic ep(input logic d, input int b, input logic [3:0] lat,
                    input logic [1:0] sm, input logic cs);
    int nb;
    int w;
    time tb;
    w = unlock_wait(d, b);
    strobe_mode_in <= sm;
    wr(1'b1, 12'(b * 8 + (d ? 4 : 0)));
    wr(1'b0, {lat, 1'b0, b[0], 6'h03});
    qw(4);
    check(parity_command_hold_out, 1, "hold on");
    check(hold_latency_style_select_out, b[0], "style");
    lfsr = rnd(lfsr);
    send({1'b0, lfsr[3:0], pcb_pkg::COL_WRITE});
    qw(3);
    check(last_cmd, {lfsr[3:0], pcb_pkg::COL_WRITE}, "held cmd");
    check(t_exec - t0 > 600, 1, "held latency");
    if (sm == pcb_pkg::STROBE_STARTSTOP)
      send({5'h00, pcb_pkg::COL_STROBE_HALT});
    qw(3);
    nb = n_exec;
    {n_minus, n_drain, n_bank, n_tog, n_tr, n_oe_low} = '0;
    send({1'b1, 4'h2, pcb_pkg::COL_READ});
    tb = t0;
    send({1'b0, 4'h3, pcb_pkg::COL_WRITE_AUTO});
    if (cs) begin
      write_checksum_fault_in <= 1'b1;
      @(posedge clk_in);
      write_checksum_fault_in <= 1'b0;
    end
    for (int k = 0; k < 400 && training_active_out !== 1'b1; k++)
      @(posedge clk_in);
    qw(2);
    check(training_active_out, 1, "training");
    check(n_exec, nb, "blocked");
    check(n_bank, 1, "bank reset");
    check(n_drain >= 8 * w - 3 && n_drain <= 8 * w + 2,
          1, "wait");
    check(n_minus, cs ? 16 : 8, "fault length");
    check(t_minus - tb >= lat * 800 + 150 &&
          t_minus - tb <= lat * 800 + 750, 1, "fault time");
    if (sm == pcb_pkg::STROBE_STARTSTOP)
      check(n_oe_low > 0, 1, "halted strobe");
    else
      check(n_tog <= n_tr / 4 + 2, 1, "slow strobe");
    send({1'b1, 4'h0, pcb_pkg::COL_TRAIN_EXIT});
    qw(2);
    check(self_refresh_out, 1, "train exit");
    if (sm == pcb_pkg::STROBE_ALWAYS)
      check(read_strobe_clock_oe_out, 1, "strobe restart");
    send({1'b1, 4'h0, pcb_pkg::COL_SLEEP_EXIT});
    qw(2);
    check(self_refresh_out | training_active_out, 0, "sleep exit");
    // Re-issue of the lost command
    send({1'b0, 4'h2, pcb_pkg::COL_READ});
    qw(3);
    check(n_exec, nb + 1, "run again");
    wr(1'b0, {lat, 8'h01});
    wr(1'b0, 12'h000);
    qw(4);
    $display("test blocked episode done");
  endtask

  always #50 clk_in = ~clk_in;

  always @(posedge clk_in) begin
    cycles++;
    if (exec_valid_out) begin
      n_exec++;
      last_cmd = {exec_row_out, exec_col_out};
      t_exec = $time;
    end
    if (fault_level_out === 2'h3) begin
      if (n_minus == 0) t_minus = $time;
      n_minus++;
    end
    n_drain += drain_req_out;
    n_bank += bank_counter_reset_out;
    n_oe_low += drain_req_out & ~read_strobe_clock_oe_out;
    if (training_active_out) begin
      n_tr++;
      n_tog += read_strobe_clock_out ^ prev_strobe;
    end
    prev_strobe = read_strobe_clock_out;
    // Whole run is under two thousand cycles
    if (cycles == 20000) begin
      miscompares++;
      tally_and_finish();
    end
  end

  initial begin
    repeat (6) @(posedge clk_in);
    reset_in <= 1'b0;
    repeat (3) @(posedge clk_in);
    @(negedge clk_in);
    check(cmd_addr_parity_check_out, 0, "parity off");
    check(parity_command_hold_out, 0, "hold off");
    check(fault_level_out, pcb_pkg::LVL_PLUS, "fault idle");
    check(info_read_word_three_out, {pcb_pkg::STYLE_BOTH, 2'h0},
          "info");
    $display("test reset done");
    n_minus = 0;
    for (int i = 0; i < 6; i++) begin
      lfsr = rnd(lfsr);
      send({lfsr[8], lfsr[3:0] | 4'h1, 2'h0, lfsr[5:4]});
      qw(2);
      check(last_cmd, {lfsr[3:0] | 4'h1, 2'h0, lfsr[5:4]}, "cmd");
      check(t_exec - t0 < 600, 1, "direct latency");
    end
    check(n_minus, 0, "no fault");
    wr(1'b0, 12'h001);
    send({1'b1, 4'h3, pcb_pkg::COL_READ});
    qw(3);
    check(last_cmd, {4'h3, pcb_pkg::COL_READ}, "unheld bad cmd");
    check(n_minus, 8, "fault count");
    $display("test unheld done");
    wr(1'b0, 12'h043);
    check(hold_latency_style_select_out, 1, "explicit");
    wr(1'b0, 12'h003);
    check(hold_latency_style_select_out, 0, "implicit");
    $display("test style done");
    ep(1'b0, 0, 4'h2, pcb_pkg::STROBE_ALWAYS, 1'b0);
    ep(1'b1, 0, 4'h0, pcb_pkg::STROBE_ALWAYS, 1'b0);
    ep(1'b1, 1, 4'h1, pcb_pkg::STROBE_ALWAYS, 1'b0);
    ep(1'b1, 2, 4'h2, pcb_pkg::STROBE_STARTSTOP, 1'b0);
    ep(1'b1, 3, 4'h0, pcb_pkg::STROBE_ALWAYS, 1'b1);
    tally_and_finish();
  end
endmodule // ca_parity_command_blocking_test

`default_nettype wire

// ---- tb/pcb_host_model.sv ----
`timescale 1ns/1ns
`default_nettype none

// Host side of the link: free running quarter clock, one command per cycle
module pcb_host_model #(
  parameter int HALF_NS  = 400,
  parameter int PHASE_NS = 137
) (
  // Bench request: parity flip, row, column
  input  wire logic [8:0] cmd_in,
  // Link pins
  output logic            qclk_out,
  output logic [3:0]      row_out,
  output logic [3:0]      col_out,
  output logic            parity_out
);
  initial begin
    qclk_out = 1'b0;
    row_out = 4'h0;
    col_out = 4'h0;
    parity_out = 1'b0;
    #(PHASE_NS);
    forever begin
      #(HALF_NS) qclk_out = ~qclk_out;
    end
  end

  // Launch on the falling edge so pins sit still around the sampling edge
  always @(negedge qclk_out) begin
    row_out    <= cmd_in[7:4];
    col_out    <= cmd_in[3:0];
    parity_out <= ^cmd_in;
  end
endmodule // pcb_host_model

`default_nettype wire
